// ---- design/acsc_top.v ----
// Purpose: Status/control register 1 logic with channel select for a 10-bit SAR converter.
// Assumes: One 40 MHz clock, synchronous active-low reset, plain register port.
// Notes:   Read data appear the cycle after the read strobe; writes never stall.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "acsc_defs.vh"
module acsc_top (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire [2:0]  i_addr,
    input  wire [7:0]  i_wr_data,
    input  wire        i_wr_en,
    input  wire        i_rd_en,
    output reg  [7:0]  o_rd_data,
    input  wire        i_hw_trigger,
    input  wire        i_cmp_hi,
    output reg  [9:0]  o_dac_code,
    output reg         o_sample,
    output reg         o_sar_power_en,
    output reg  [27:0] o_chan_enable,
    output reg         o_sel_refh,
    output reg         o_sel_refl,
    output reg         o_irq
);
    // Software-visible state.
    reg        flag_r;
    reg        ien_r;
    reg        cont_r;
    reg [4:0]  chan_r;
    reg        trig_sel_r;
    reg        cfe_r;
    reg        cgt_r;
    reg [9:0]  cv_r;
    reg [9:0]  res_r;
    reg        lock_r;
    reg [`ACSC_EV_W-1:0] ev_stat_r;
    reg [`ACSC_EV_W-1:0] ev_mask_r;
    reg        run_r;

    // Synchronisers for the two outside pins.
    reg        trg_s1_r;
    reg        trg_s2_r;
    reg        trg_s3_r;
    reg        cmp_s1_r;
    reg        cmp_s2_r;

    // Sequencer and decoder connections.
    wire       sar_busy;
    wire       sar_sample;
    wire       sar_done;
    wire [9:0] sar_dac;
    wire [9:0] sar_result;
    wire [27:0] dec_enable;
    wire       dec_refh;
    wire       dec_refl;
    wire       dec_disable;

    // Access strobes decoded once.
    wire wr_sc1  = i_wr_en && (i_addr == `ACSC_ADDR_SC1);
    wire wr_sc2  = i_wr_en && (i_addr == `ACSC_ADDR_SC2);
    wire wr_cvh  = i_wr_en && (i_addr == `ACSC_ADDR_CVH);
    wire wr_cvl  = i_wr_en && (i_addr == `ACSC_ADDR_CVL);
    wire wr_stat = i_wr_en && (i_addr == `ACSC_ADDR_IRQ_STAT);
    wire wr_mask = i_wr_en && (i_addr == `ACSC_ADDR_IRQ_MASK);
    wire rd_resh = i_rd_en && (i_addr == `ACSC_ADDR_RESH);
    wire rd_resl = i_rd_en && (i_addr == `ACSC_ADDR_RESL);

    wire [4:0] wr_chan   = i_wr_data[`ACSC_CH_MSB:0];
    wire       wr_ch_off = (wr_chan == `ACSC_CH_DISABLE);
    wire       ch_off    = (chan_r == `ACSC_CH_DISABLE);

    // A trigger is a rising edge seen on the second and third stages only.
    wire trg_edge = trg_s2_r && !trg_s3_r;

    // A completion in a control write's cycle belongs to the aborted run.
    wire done_ok = sar_done && !wr_sc1;

    // Compare condition: at-or-above when greater-than is selected, else below.
    wire cmp_true = cgt_r ? (sar_result >= cv_r) : (sar_result < cv_r);
    wire report   = done_ok && (!cfe_r || cmp_true);

    // Start sources.
    wire start_sw = wr_sc1 && !wr_ch_off && !trig_sel_r;
    wire start_hw = trg_edge && trig_sel_r && !ch_off && !sar_busy
                    && !wr_sc1 && (!cont_r || !run_r);
    wire start_ct = done_ok && run_r && cont_r && !ch_off;
    wire start_any = start_sw || start_hw || start_ct;

    acsc_sar_seq u_sar (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_start   (start_any),
        .i_abort   (wr_sc1),
        .i_cmp_hi  (cmp_s2_r),
        .o_busy    (sar_busy),
        .o_sample  (sar_sample),
        .o_done    (sar_done),
        .o_dac     (sar_dac),
        .o_result  (sar_result)
    );

    acsc_chan_decode u_dec (
        .i_code    (chan_r),
        .o_enable  (dec_enable),
        .o_refh    (dec_refh),
        .o_refl    (dec_refl),
        .o_disable (dec_disable)
    );

    // Three flip-flops on the trigger pin and two on the comparator pin; the first stage feeds no logic.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            trg_s1_r <= 1'b0;
            trg_s2_r <= 1'b0;
            trg_s3_r <= 1'b0;
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            trg_s1_r <= i_hw_trigger;
            trg_s2_r <= trg_s1_r;
            trg_s3_r <= trg_s2_r;
            cmp_s1_r <= i_cmp_hi;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // Control register 1 and the continuous-run marker.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ien_r  <= 1'b0;
            cont_r <= 1'b0;
            chan_r <= `ACSC_CH_DISABLE;
            run_r  <= 1'b0;
        end else begin
            if (wr_sc1) begin
                ien_r  <= i_wr_data[`ACSC_SC1_IEN_BIT];
                cont_r <= i_wr_data[`ACSC_SC1_CONT_BIT];
                chan_r <= wr_chan;
            end
            // The run marker drops on any control write that does not itself restart.
            if (start_sw || start_hw) begin
                run_r <= 1'b1;
            end else if (wr_sc1) begin
                run_r <= 1'b0;
            end else if (sar_done && !cont_r) begin
                run_r <= 1'b0;
            end
        end
    end

    // Completion flag: hardware set wins over a same-cycle result-low read.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            flag_r <= 1'b0;
        end else if (report) begin
            flag_r <= 1'b1;
        end else if (wr_sc1 || rd_resl) begin
            flag_r <= 1'b0;
        end
    end

    // Control register 2 and compare value.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            trig_sel_r <= 1'b0;
            cfe_r      <= 1'b0;
            cgt_r      <= 1'b0;
            cv_r       <= 10'h000;
        end else begin
            if (wr_sc2) begin
                trig_sel_r <= i_wr_data[`ACSC_SC2_TRG_BIT];
                cfe_r      <= i_wr_data[`ACSC_SC2_CFE_BIT];
                cgt_r      <= i_wr_data[`ACSC_SC2_CGT_BIT];
            end
            if (wr_cvh) begin
                cv_r[9:8] <= i_wr_data[1:0];
            end
            if (wr_cvl) begin
                cv_r[7:0] <= i_wr_data;
            end
        end
    end

    // Reading the high byte freezes the result until the low byte is read.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            res_r  <= 10'h000;
            lock_r <= 1'b0;
        end else begin
            if (report && !lock_r) begin
                res_r <= sar_result;
            end
            if (rd_resh) begin
                lock_r <= 1'b1;
            end else if (rd_resl) begin
                lock_r <= 1'b0;
            end
        end
    end

    // Sticky event bits, cleared by writing one; a new event wins over the clear.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ev_stat_r <= {`ACSC_EV_W{1'b0}};
            ev_mask_r <= {`ACSC_EV_W{1'b0}};
        end else begin
            ev_stat_r[`ACSC_EV_DONE] <= done_ok
                || (ev_stat_r[`ACSC_EV_DONE] && !(wr_stat && i_wr_data[`ACSC_EV_DONE]));
            ev_stat_r[`ACSC_EV_MATCH] <= (done_ok && cfe_r && cmp_true)
                || (ev_stat_r[`ACSC_EV_MATCH] && !(wr_stat && i_wr_data[`ACSC_EV_MATCH]));
            ev_stat_r[`ACSC_EV_OVERRUN] <= (report && lock_r)
                || (ev_stat_r[`ACSC_EV_OVERRUN] && !(wr_stat && i_wr_data[`ACSC_EV_OVERRUN]));
            if (wr_mask) begin
                ev_mask_r <= i_wr_data[`ACSC_EV_W-1:0];
            end
        end
    end

    // Interrupt level; registered, so it follows the flag by one cycle.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (flag_r && ien_r) || (|(ev_stat_r & ev_mask_r));
        end
    end

    // Analog-side controls; power follows activity, so a single conversion
    // drops to low power by itself.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sar_power_en <= 1'b0;
            o_chan_enable  <= 28'h000_0000;
            o_sel_refh     <= 1'b0;
            o_sel_refl     <= 1'b0;
            o_dac_code     <= 10'h000;
            o_sample       <= 1'b0;
        end else begin
            o_sar_power_en <= !dec_disable && (sar_busy || start_any);
            o_chan_enable  <= dec_disable ? 28'h000_0000 : dec_enable;
            o_sel_refh     <= dec_refh;
            o_sel_refl     <= dec_refl;
            o_dac_code     <= sar_dac;
            o_sample       <= sar_sample && !dec_disable;
        end
    end

    // Read data mux, valid the cycle after the strobe and zero otherwise.
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rd_data <= `ACSC_ZERO8;
        end else if (i_rd_en) begin
            case (i_addr)
                `ACSC_ADDR_SC1:      o_rd_data <= {flag_r, ien_r, cont_r, chan_r};
                `ACSC_ADDR_SC2:      o_rd_data <= {sar_busy, trig_sel_r, cfe_r, cgt_r,
                                                   4'h0};
                `ACSC_ADDR_RESH:     o_rd_data <= {6'h00, res_r[9:8]};
                `ACSC_ADDR_RESL:     o_rd_data <= res_r[7:0];
                `ACSC_ADDR_CVH:      o_rd_data <= {6'h00, cv_r[9:8]};
                `ACSC_ADDR_CVL:      o_rd_data <= cv_r[7:0];
                `ACSC_ADDR_IRQ_STAT: o_rd_data <= {5'h00, ev_stat_r};
                `ACSC_ADDR_IRQ_MASK: o_rd_data <= {5'h00, ev_mask_r};
                default:             o_rd_data <= `ACSC_ZERO8;
            endcase
        end else begin
            o_rd_data <= `ACSC_ZERO8;
        end
    end
endmodule // acsc_top
`default_nettype wire

// ---- pkg/acsc_defs.vh ----
// Purpose: Constants for the converter status/control channel-select block.
// Assumes: 40 MHz system clock, 8-bit register port with 3 address bits.
// Notes:   Offsets, fields, reset values and timing counts.
//
// Functional notes
// - A control write aborts any conversion and, with software trigger selected, starts a new one unless the code is all ones.
// - With compare off, the completion flag (bit 7) sets at every conversion end.
// - With compare on, the flag sets at a conversion end only if the compare is true.
// - The flag clears on any control write or result low read.
// - The completion interrupt is requested while the flag and its enable (bit 6) are high.
// - With continuous mode (bit 5) off, one conversion per write or trigger, then idle.
// - With continuous mode on, conversions run back to back once a write or trigger starts them.
// - The channel code (bits 4:0) picks inputs 0-27, reserved, high or low reference, or disable.
// - Code all ones powers the converter down and isolates every input.
// - Ending continuous mode with code all ones leaves no further conversion.
// - Without continuous mode the converter drops to low power after each conversion.
// - The trigger select chooses start on a control write or on a hardware trigger.
// - The active bit is high from a conversion's start until it completes or is aborted.
`ifndef ACSC_DEFS_VH
`define ACSC_DEFS_VH

// Register index on the 3-bit port.
`define ACSC_ADDR_SC1      3'h0
`define ACSC_ADDR_SC2      3'h1
`define ACSC_ADDR_RESH     3'h2
`define ACSC_ADDR_RESL     3'h3
`define ACSC_ADDR_CVH      3'h4
`define ACSC_ADDR_CVL      3'h5
`define ACSC_ADDR_IRQ_STAT 3'h6
`define ACSC_ADDR_IRQ_MASK 3'h7

// Status/control 1 fields.
`define ACSC_SC1_FLAG_BIT  7
`define ACSC_SC1_IEN_BIT   6
`define ACSC_SC1_CONT_BIT  5
`define ACSC_CH_MSB        4
`define ACSC_CH_DISABLE    5'h1F
`define ACSC_CH_REFH       5'h1D
`define ACSC_CH_REFL       5'h1E
`define ACSC_CH_LAST_INPUT 5'h1B

// Status/control 2 fields.
`define ACSC_SC2_ACT_BIT   7
`define ACSC_SC2_TRG_BIT   6
`define ACSC_SC2_CFE_BIT   5
`define ACSC_SC2_CGT_BIT   4

// Interrupt status bits.
`define ACSC_EV_DONE       0
`define ACSC_EV_MATCH      1
`define ACSC_EV_OVERRUN    2
`define ACSC_EV_W          3

// Reset values.
`define ACSC_SC1_RESET     8'h1F
`define ACSC_ZERO8         8'h00

// Timing in clock cycles: sample window and per-bit settle time.
`define ACSC_SAMPLE_CYC    8
`define ACSC_BIT_CYC       4

`endif

// ---- design/acsc_chan_decode.v ----
// Purpose: Turns the 5-bit channel code into input switch enables.
// Assumes: Caller registers the outputs.
// Notes:   Reserved and disable codes open every switch.
`timescale 1ns/100ps
`default_nettype none
`include "acsc_defs.vh"
module acsc_chan_decode (
    input  wire [4:0]  i_code,
    output wire [27:0] o_enable,
    output wire        o_refh,
    output wire        o_refl,
    output wire        o_disable
);
    // One-hot decode of ordinary inputs only.
    function [27:0] onehot;
        input [4:0] code;
        begin
            onehot = 28'h000_0000;
            if (code <= `ACSC_CH_LAST_INPUT) begin
                onehot[code] = 1'b1;
            end
        end
    endfunction

    assign o_enable  = onehot(i_code);
    assign o_refh    = (i_code == `ACSC_CH_REFH);
    assign o_refl    = (i_code == `ACSC_CH_REFL);
    assign o_disable = (i_code == `ACSC_CH_DISABLE);
endmodule // acsc_chan_decode
`default_nettype wire

// ---- design/acsc_sar_seq.v ----
// Purpose: Successive approximation sequencer, sample phase then ten bit trials.
// Assumes: i_cmp_hi is already synchronised and means input above the DAC code.
// Notes:   A start always wins over an abort in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "acsc_defs.vh"
module acsc_sar_seq (
    input  wire       i_clk_sys,
    input  wire       i_rst_n,
    input  wire       i_start,
    input  wire       i_abort,
    input  wire       i_cmp_hi,
    output reg        o_busy,
    output reg        o_sample,
    output reg        o_done,
    output reg  [9:0] o_dac,
    output reg  [9:0] o_result
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_SMP  = 2'b01;
    localparam [1:0] ST_BIT  = 2'b10;
    localparam integer SMP_LAST = `ACSC_SAMPLE_CYC - 1;
    localparam integer BIT_LAST = `ACSC_BIT_CYC - 1;

    reg [1:0] state_r;
    reg [7:0] cnt_r;
    reg [3:0] idx_r;

    // The comparator is read in a bit's last cycle, once DAC and sync settle.
    always @(posedge i_clk_sys) begin
        o_done <= 1'b0;
        if (!i_rst_n) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 8'h00;
            idx_r    <= 4'h0;
            o_busy   <= 1'b0;
            o_sample <= 1'b0;
            o_dac    <= 10'h000;
            o_result <= 10'h000;
        end else if (i_start) begin
            state_r  <= ST_SMP;
            cnt_r    <= 8'h00;
            o_busy   <= 1'b1;
            o_sample <= 1'b1;
            o_dac    <= 10'h000;
        end else if (i_abort) begin
            state_r  <= ST_IDLE;
            o_busy   <= 1'b0;
            o_sample <= 1'b0;
        end else begin
            case (state_r)
                ST_SMP: begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == SMP_LAST[7:0]) begin
                        state_r  <= ST_BIT;
                        cnt_r    <= 8'h00;
                        idx_r    <= 4'd9;
                        o_sample <= 1'b0;
                        o_dac    <= 10'h200;
                    end
                end
                ST_BIT: begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == BIT_LAST[7:0]) begin
                        cnt_r <= 8'h00;
                        if (idx_r == 4'h0) begin
                            state_r  <= ST_IDLE;
                            o_busy   <= 1'b0;
                            o_done   <= 1'b1;
                            o_result <= i_cmp_hi ? o_dac : (o_dac & 10'h3FE);
                        end else begin
                            idx_r <= idx_r - 4'h1;
                            o_dac <= (i_cmp_hi ? o_dac : (o_dac & ~(10'h001 << idx_r)))
                                     | (10'h001 << (idx_r - 4'h1));
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // acsc_sar_seq
`default_nettype wire

// ---- sim/acsc_top_properties.sv ----
// Purpose: Concurrent checks on the ports of the status/control block.
// Assumes: One clock, synchronous active-low reset, no write during a sample phase.
// Notes:   Helper registers shadow the software-written control fields.
`timescale 1ns/100ps
`default_nettype none
`include "acsc_defs.vh"
module acsc_props (
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic [2:0]  i_addr,
    input wire logic [7:0]  i_wr_data,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [7:0]  o_rd_data,
    input wire logic        o_sample,
    input wire logic        o_sar_power_en,
    input wire logic [27:0] o_chan_enable,
    input wire logic        o_sel_refh,
    input wire logic        o_sel_refl,
    input wire logic        o_irq
);
    logic [4:0]  ch_r;
    logic        cont_r;
    logic        trg_r;
    logic        run_ok_r;
    logic [5:0]  age_r;
    logic [5:0]  cnt_r;
    wire         wr_sc1 = i_wr_en && (i_addr == `ACSC_ADDR_SC1);
    wire  [27:0] exp_en = (ch_r <= `ACSC_CH_LAST_INPUT) ? (28'h000_0001 << ch_r) : 28'h000_0000;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // Shadow the control fields and time the run; a control write aborts it.
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ch_r     <= `ACSC_CH_DISABLE;
            cont_r   <= 1'b0;
            trg_r    <= 1'b0;
            age_r    <= 6'h03;
            cnt_r    <= 6'h00;
            run_ok_r <= 1'b0;
        end else begin
            if (wr_sc1) begin
                ch_r   <= i_wr_data[4:0];
                cont_r <= i_wr_data[`ACSC_SC1_CONT_BIT];
                age_r  <= 6'h00;
            end else if (age_r != 6'h3F) begin
                age_r <= age_r + 6'h01;
            end
            if (i_wr_en && (i_addr == `ACSC_ADDR_SC2)) begin
                trg_r <= i_wr_data[`ACSC_SC2_TRG_BIT];
            end
            if ($rose(o_sample)) begin
                cnt_r <= 6'h01;
            end else if (cnt_r != 6'h3F) begin
                cnt_r <= cnt_r + 6'h01;
            end
            run_ok_r <= $rose(o_sample) || (run_ok_r && !wr_sc1);
        end
    end

    chan_decode_a: assert property (age_r >= 6'h03 |-> o_chan_enable == exp_en)
        else $error("switches differ from code");
    ref_select_a: assert property (age_r >= 6'h03 |->
        o_sel_refh == (ch_r == `ACSC_CH_REFH) && o_sel_refl == (ch_r == `ACSC_CH_REFL))
        else $error("reference selects differ from code");
    disable_off_a: assert property (age_r >= 6'h03 && ch_r == `ACSC_CH_DISABLE |->
        !o_sar_power_en && !o_sample && o_chan_enable == 28'h000_0000)
        else $error("converter on with disable code");
    sw_start_a: assert property (wr_sc1 && !trg_r && i_wr_data[4:0] != `ACSC_CH_DISABLE
        |-> ##[1:3] (o_sar_power_en && o_sample))
        else $error("write did not start a conversion");
    sample_len_a: assert property ($rose(o_sample) |-> o_sample [*8] ##1 !o_sample)
        else $error("sample phase length wrong");
    active_hold_a: assert property (run_ok_r && cnt_r == 6'h28 |-> o_sar_power_en)
        else $error("power lost in mid conversion");
    single_idle_a: assert property (run_ok_r && !cont_r && cnt_r == 6'h3C
        |-> !o_sar_power_en && !o_sample)
        else $error("single conversion left power on");
    cont_run_a: assert property (run_ok_r && cont_r |-> cnt_r <= 6'h38)
        else $error("continuous conversions stopped");
    rd_field_a: assert property ($past(i_rd_en) && $past(i_addr) == `ACSC_ADDR_SC1
        |-> o_rd_data[5:0] == {$past(cont_r), $past(ch_r)})
        else $error("control read back differs");

    cover property ($rose(o_irq));
    cover property (run_ok_r && cont_r && $rose(o_sample));
    cover property (wr_sc1 && trg_r);
endmodule // acsc_props

bind acsc_top acsc_props u_props (
    .i_clk_sys      (i_clk_sys),
    .i_rst_n        (i_rst_n),
    .i_addr         (i_addr),
    .i_wr_data      (i_wr_data),
    .i_wr_en        (i_wr_en),
    .i_rd_en        (i_rd_en),
    .o_rd_data      (o_rd_data),
    .o_sample       (o_sample),
    .o_sar_power_en (o_sar_power_en),
    .o_chan_enable  (o_chan_enable),
    .o_sel_refh     (o_sel_refh),
    .o_sel_refl     (o_sel_refl),
    .o_irq          (o_irq)
);
`default_nettype wire

// ---- sim/acsc_top_bench.sv ----
// Purpose: Self-checking bench for the status/control block with channel select.
// Assumes: 40 MHz clock, synchronous active-low reset, plain register port.
// Notes:   One task per scenario; a cycle ceiling cuts a hang short.
`timescale 1ns/100ps
`default_nettype none
`include "acsc_defs.vh"
`define CHK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module acsc_top_bench;
    logic        i_clk_sys    = 1'b0;
    logic        i_rst_n      = 1'b0;
    logic [2:0]  i_addr       = 3'h0;
    logic [7:0]  i_wr_data    = 8'h00;
    logic        i_wr_en      = 1'b0;
    logic        i_rd_en      = 1'b0;
    logic        i_hw_trigger = 1'b0;
    logic        i_cmp_hi     = 1'b0;
    wire  [7:0]  o_rd_data;
    wire  [9:0]  o_dac_code;
    wire         o_sample;
    wire         o_sar_power_en;
    wire  [27:0] o_chan_enable;
    wire         o_sel_refh;
    wire         o_sel_refl;
    wire         o_irq;
    int          bad_count    = 0;
    int          tests_run    = 0;
    int          cycles       = 0;

    acsc_top u_dut (
        .i_clk_sys      (i_clk_sys),
        .i_rst_n        (i_rst_n),
        .i_addr         (i_addr),
        .i_wr_data      (i_wr_data),
        .i_wr_en        (i_wr_en),
        .i_rd_en        (i_rd_en),
        .o_rd_data      (o_rd_data),
        .i_hw_trigger   (i_hw_trigger),
        .i_cmp_hi       (i_cmp_hi),
        .o_dac_code     (o_dac_code),
        .o_sample       (o_sample),
        .o_sar_power_en (o_sar_power_en),
        .o_chan_enable  (o_chan_enable),
        .o_sel_refh     (o_sel_refh),
        .o_sel_refl     (o_sel_refl),
        .o_irq          (o_irq)
    );

    // Clock at 25 ns.
    always #12.5 i_clk_sys = ~i_clk_sys;

    task automatic finish_test();
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A whole run needs under 2000 cycles, so this ceiling only trips on a hang.
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end

    // Waits n edges, then settles past them before sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr    <= a;
        i_wr_data <= d;
        i_wr_en   <= 1'b1;
        @(posedge i_clk_sys);
        i_wr_en   <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_rd_en <= 1'b1;
        @(posedge i_clk_sys);
        i_rd_en <= 1'b0;
        #1;
        `CHK(what, exp, o_rd_data)
    endtask

    // Bounded by the cycle ceiling should the converter never go idle.
    task automatic wait_idle();
        tick(4);
        while (o_sar_power_en !== 1'b0) tick(1);
        tick(3);
    endtask

    task automatic t_reset();
        rd_chk(`ACSC_ADDR_SC1, `ACSC_SC1_RESET, "control one at reset");
        rd_chk(`ACSC_ADDR_SC2, 8'h00, "control two at reset");
        wr(`ACSC_ADDR_RESL, 8'hA5);
        rd_chk(`ACSC_ADDR_RESL, 8'h00, "result low is read only");
        `CHK("power at reset", 1'b0, o_sar_power_en)
    endtask

    // Hardware trigger selected, so each write only steers the switches.
    task automatic t_decode();
        wr(`ACSC_ADDR_SC2, 8'h40);
        for (int c = 0; c < 32; c++) begin
            wr(`ACSC_ADDR_SC1, {3'h0, c[4:0]});
            tick(3);
            `CHK("switches", (c < 28) ? (28'h000_0001 << c) : 28'h000_0000, o_chan_enable)
            `CHK("references", {c == 29, c == 30}, {o_sel_refh, o_sel_refl})
            `CHK("no start on write", 1'b0, o_sar_power_en)
        end
    endtask

    task automatic t_hw_trig();
        wr(`ACSC_ADDR_SC1, 8'h04);
        tick(10);
        `CHK("waits for trigger", 1'b0, o_sar_power_en)
        @(posedge i_clk_sys);
        i_hw_trigger <= 1'b1;
        tick(8);
        `CHK("trigger starts", 1'b1, o_sar_power_en)
        rd_chk(`ACSC_ADDR_SC2, 8'hC0, "active in run");
        @(posedge i_clk_sys);
        i_hw_trigger <= 1'b0;
        wait_idle();
        rd_chk(`ACSC_ADDR_SC1, 8'h84, "flag after trigger");
        tick(60);
        `CHK("one per trigger", 1'b0, o_sar_power_en)
        wr(`ACSC_ADDR_SC2, 8'h00);
    endtask

    // Comparator always high, so every trial bit is kept and the result is all ones.
    task automatic t_single();
        @(posedge i_clk_sys);
        i_cmp_hi <= 1'b1;
        wr(`ACSC_ADDR_SC1, 8'h43);
        rd_chk(`ACSC_ADDR_SC1, 8'h43, "flag cleared by write");
        wait_idle();
        `CHK("irq with enable", 1'b1, o_irq)
        `CHK("dac code", 10'h3FF, o_dac_code)
        rd_chk(`ACSC_ADDR_SC1, 8'hC3, "flag after single");
        rd_chk(`ACSC_ADDR_RESH, 8'h03, "result high");
        rd_chk(`ACSC_ADDR_RESL, 8'hFF, "result low");
        tick(2);
        `CHK("irq after result read", 1'b0, o_irq)
        rd_chk(`ACSC_ADDR_SC1, 8'h43, "flag cleared by result read");
        tick(60);
        `CHK("single stays idle", 1'b0, o_sar_power_en)
    endtask

    task automatic t_irq();
        wr(`ACSC_ADDR_IRQ_STAT, 8'h07);
        wr(`ACSC_ADDR_IRQ_MASK, 8'h01);
        wr(`ACSC_ADDR_SC1, 8'h03);
        wait_idle();
        `CHK("irq from done event", 1'b1, o_irq)
        rd_chk(`ACSC_ADDR_IRQ_STAT, 8'h01, "done event");
        wr(`ACSC_ADDR_IRQ_STAT, 8'h01);
        tick(2);
        `CHK("irq after event clear", 1'b0, o_irq)
        rd_chk(`ACSC_ADDR_SC1, 8'h83, "flag without enable");
        wr(`ACSC_ADDR_IRQ_MASK, 8'h00);
        wr(`ACSC_ADDR_SC1, 8'h03);
        wait_idle();
        `CHK("irq masked", 1'b0, o_irq)
    endtask

    // The restart lands in the bit phase; the first run would end before the read.
    task automatic t_abort();
        wr(`ACSC_ADDR_SC1, 8'h05);
        tick(30);
        wr(`ACSC_ADDR_SC1, 8'h05);
        tick(22);
        rd_chk(`ACSC_ADDR_SC1, 8'h05, "aborted run silent");
        wait_idle();
        rd_chk(`ACSC_ADDR_SC1, 8'h85, "restarted run reports");
    endtask

    // Compare value 0x200, greater-or-equal: result 0 fails, result 0x3FF passes.
    task automatic t_compare();
        wr(`ACSC_ADDR_CVH, 8'h02);
        wr(`ACSC_ADDR_CVL, 8'h00);
        wr(`ACSC_ADDR_SC2, 8'h30);
        @(posedge i_clk_sys);
        i_cmp_hi <= 1'b0;
        wr(`ACSC_ADDR_SC1, 8'h05);
        wait_idle();
        rd_chk(`ACSC_ADDR_SC1, 8'h05, "false compare leaves flag");
        @(posedge i_clk_sys);
        i_cmp_hi <= 1'b1;
        wr(`ACSC_ADDR_SC1, 8'h05);
        wait_idle();
        rd_chk(`ACSC_ADDR_SC1, 8'h85, "true compare sets flag");
        rd_chk(`ACSC_ADDR_RESL, 8'hFF, "result on true compare");
        wr(`ACSC_ADDR_SC2, 8'h00);
    endtask

    // The stop write is placed in a bit phase so no sample phase is cut short.
    task automatic t_cont();
        wr(`ACSC_ADDR_SC1, 8'h22);
        tick(150);
        `CHK("continuous running", 1'b1, o_sar_power_en)
        rd_chk(`ACSC_ADDR_SC1, 8'hA2, "continuous completes");
        while (o_sample !== 1'b1) tick(1);
        while (o_sample !== 1'b0) tick(1);
        tick(5);
        wr(`ACSC_ADDR_SC1, 8'h3F);
        tick(3);
        `CHK("disable powers down", 1'b0, o_sar_power_en)
        tick(100);
        `CHK("no trailing conversion", 1'b0, o_sar_power_en | o_sample)
        rd_chk(`ACSC_ADDR_SC1, 8'h3F, "disable write clears flag");
    endtask

    // Reset for two cycles, then the scenarios in turn.
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        t_reset();
        t_decode();
        t_hw_trig();
        t_single();
        t_irq();
        t_abort();
        t_compare();
        t_cont();
        finish_test();
    end
endmodule // acsc_top_bench
`default_nettype wire
